// [pkg/smot_pkg.sv]
/*
 * shared constants and types for the spi mode-one transfer block.
 * assumes a 100 MHz core clock; timing counts are derived from it here.
 */
package smot_pkg;

	// core clock rate and chip-select timing in nanoseconds
	localparam int unsigned CORE_MHZ = 100;
	localparam int unsigned CS_SETUP_NS = 40;
	localparam int unsigned CS_HOLD_NS = 40;
	// least times round up to whole core cycles
	localparam int unsigned CS_SETUP_CYC = (CS_SETUP_NS * CORE_MHZ + 999) / 1000;
	localparam int unsigned CS_HOLD_CYC = (CS_HOLD_NS * CORE_MHZ + 999) / 1000;

	// structural defaults
	localparam int unsigned FRAME_BITS_DEF = 8;
	localparam int unsigned SCK_HALF_DEF = 4;
	localparam int unsigned CS_NUM_DEF = 4;
	localparam int unsigned CNT_W = 16;
	localparam int unsigned FCNT_W = 8;

	// line levels
	localparam logic SCK_MARK = 1'b1;
	localparam logic DOUT_IDLE = 1'b1;
	localparam logic CS_OFF = 1'b1;

	// interframe wait selections
	localparam logic [1:0] WAIT_NONE = 2'h0;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_SETUP = 5'h02,
		ST_SHIFT = 5'h04,
		ST_WAIT = 5'h08,
		ST_HOLD = 5'h10
	} smot_state_t;

endpackage

// [src/smot_sync.sv]
/*
 * two-flop synchroniser for a group of independent levels or toggles.
 * assumes each bit changes slowly against the destination clock.
 */
`timescale 1ns/10ps
module smot_sync #(
	parameter int unsigned W = 1
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_q;

	// first stage feeds only the second
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule

// [src/smot_spi1.sv]
/*
 * spi mode-one transfer engine: clock idles high, data out on rising edge,
 * data in on falling edge. master side runs on core_clk and divides its own
 * serial clock; slave side runs on the incoming serial clock (sck_link).
 * assumes configuration ports are held steady while a frame is on the wire.
 */
// What this block does
// - serial clock idles high, output changes on rise, input sampled on fall.
// - nonzero interframe wait selection inserts idle clock time between frames.
// - master with wait selection three holds clock three bit times.
// - slave transmit write clears empty flag, drives first bit, rest on rises.
// - slave sets empty flag after the first external falling edge, transmit request if enabled.
// - slave receive samples incoming bits on each external falling edge.
// - last bit sets full flag, receive request if enabled, data readable.
// - reading receive data clears the full flag.
// - slave receive-then-transmit: dummy write at idle starts reception.
// - switching to transmit: device drives written data on rises after reception.
// - master write clears empty flag, drives first bit, asserts select.
// - master sets empty flag half a clock before first falling edge.
// - master with select stops clock after programmed frame count.
// - select releases after hold time unless hold-active is set.
// - fifo frame count write makes master clock exactly that many frames.
`timescale 1ns/10ps
module smot_spi1 import smot_pkg::*; #(
	parameter int unsigned FRAME_BITS = FRAME_BITS_DEF,
	parameter int unsigned SCK_HALF = SCK_HALF_DEF,
	parameter int unsigned CS_NUM = CS_NUM_DEF
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic sck_link,
	input wire logic serial_in_pin,
	input wire logic slave_mode_select,
	input wire logic clock_output_enable,
	input wire logic serial_out_enable,
	input wire logic tx_enable,
	input wire logic rx_enable,
	input wire logic tx_int_enable,
	input wire logic rx_int_enable,
	input wire logic interframe_wait_sel_hi,
	input wire logic interframe_wait_sel_lo,
	input wire logic cs_output_enable,
	input wire logic [CS_NUM-1:0] cs_pin_enable,
	input wire logic [$clog2(CS_NUM)-1:0] cs_index,
	input wire logic cs_hold_active,
	input wire logic [FCNT_W-1:0] frame_count,
	input wire logic fifo_enable,
	input wire logic [FCNT_W-1:0] fifo_frame_count,
	input wire logic fifo_frame_we,
	input wire logic [FRAME_BITS-1:0] tx_data_reg,
	input wire logic tx_data_we,
	input wire logic rx_data_re,
	output logic [FRAME_BITS-1:0] rx_data_reg,
	output logic tx_buffer_empty_flag,
	output logic rx_buffer_full_flag,
	output logic tx_irq,
	output logic rx_irq,
	output logic sck_out,
	output logic sck_oe,
	output logic serial_out_pin,
	output logic [CS_NUM-1:0] chip_select_pin_n
);

	localparam int unsigned MSB = FRAME_BITS - 1;
	localparam int unsigned BIT_W = $clog2(FRAME_BITS + 1);
	localparam int unsigned CS_W = $clog2(CS_NUM);
	localparam logic [CNT_W-1:0] HALF_LIM = CNT_W'(SCK_HALF - 1);
	localparam logic [CNT_W-1:0] SETUP_LIM = CNT_W'(CS_SETUP_CYC - 1);
	localparam logic [CNT_W-1:0] HOLD_LIM = CNT_W'(CS_HOLD_CYC - 1);
	localparam logic [BIT_W-1:0] LAST_BIT = BIT_W'(MSB);

	// one-hot select pattern, gated by the pin enables
	function automatic logic [CS_NUM-1:0] cs_decode(input logic [CS_W-1:0] idx, input logic [CS_NUM-1:0] en);
		logic [CS_NUM-1:0] one;
		one = {{(CS_NUM - 1){1'b0}}, 1'b1};
		cs_decode = en & (one << idx);
	endfunction

	// wait length in core cycles: sel bit times of two half periods each
	function automatic logic [CNT_W-1:0] wait_lim(input logic [1:0] sel);
		logic [CNT_W-1:0] bits;
		bits = {{(CNT_W - 2){1'b0}}, sel};
		wait_lim = bits * CNT_W'(2 * SCK_HALF) - CNT_W'(1);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// declarations

	smot_state_t state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d, cnt_lim;
	logic sck_q, sck_oe_q, dout_q;
	logic [BIT_W-1:0] bit_q;
	logic [FRAME_BITS-1:0] tx_sh_q, rx_sh_q, tx_hold_q, rx_data_q;
	logic [FCNT_W-1:0] frames_q;
	logic count_mode_q, fifo_go_q, cs_used_q;
	logic [CS_NUM-1:0] cs_n_q;
	logic tx_empty_q, rx_full_q, tx_irq_q, rx_irq_q, armed_q;
	// link side
	logic [BIT_W-1:0] lcnt_q;
	logic [FRAME_BITS-1:0] lrx_sh_q, lrx_word_q, ltx_word_q;
	logic lrx_tgl_q, lst_tgl_q, slv_dout_q, lfirst_q;
	// crossing
	logic [2:0] sync_q;
	logic rx_tgl_old_q, st_tgl_old_q;

	////////////////////////////////////////////////////////////////////////
	// decode

	wire [1:0] wait_sel = {interframe_wait_sel_hi, interframe_wait_sel_lo};
	wire master = !slave_mode_select && clock_output_enable;
	wire slave = slave_mode_select && !clock_output_enable;
	wire [CS_NUM-1:0] cs_pick = cs_decode(cs_index, cs_pin_enable);
	wire cs_mode = cs_output_enable && (|cs_pick);
	wire st_idle = state_q == ST_IDLE;
	wire st_setup = state_q == ST_SETUP;
	wire st_shift = state_q == ST_SHIFT;
	wire st_wait = state_q == ST_WAIT;
	wire st_hold = state_q == ST_HOLD;
	wire cnt_end = cnt_q == cnt_lim;
	wire sin_s = sync_q[2];
	wire slv_rx_ev = sync_q[1] ^ rx_tgl_old_q;
	wire slv_st_ev = sync_q[0] ^ st_tgl_old_q;
	wire tx_wr = tx_data_we && tx_enable;

	// half period, setup, hold or wait length for the running state
	assign cnt_lim = st_setup ? SETUP_LIM : st_hold ? HOLD_LIM : st_wait ? wait_lim(wait_sel) : HALF_LIM;

	wire fall = st_shift && cnt_end && (sck_q == SCK_MARK);
	wire rise = st_shift && cnt_end && (sck_q != SCK_MARK);
	wire last_bit = bit_q == LAST_BIT;
	wire frame_end = rise && last_bit;
	wire bit_step = rise && !last_bit;

	// counted mode runs out its frames; otherwise keep going on fresh data
	wire more = count_mode_q ? (frames_q > FCNT_W'(1)) : !tx_empty_q;
	// a transmit write or a fifo count write is what starts the clock
	wire start_ok = st_idle && master && tx_enable && (!tx_empty_q || fifo_go_q);
	// wait only when the selection is nonzero
	wire wait_go = frame_end && more && (wait_sel != WAIT_NONE);
	wire load = start_ok || (frame_end && more && !wait_go) || (st_wait && cnt_end);
	// buffer released with the clock high, half period before the fall
	wire m_take = (load && !(st_idle && cs_mode)) || (st_setup && cnt_end);
	// slave releases the buffer when its first bit went out
	wire s_take = slv_st_ev && slave && serial_out_enable && tx_enable;
	// slave data counts only when armed by a dummy write, or receive-only
	wire s_rx_ok = slv_rx_ev && slave && rx_enable && (armed_q || !tx_enable);
	wire rx_new = (frame_end && master && rx_enable) || s_rx_ok;

	////////////////////////////////////////////////////////////////////////
	// master sequencer

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (start_ok)
					state_d = cs_mode ? ST_SETUP : ST_SHIFT;
			end
			ST_SETUP: begin
				if (cnt_end)
					state_d = ST_SHIFT;
			end
			ST_SHIFT: begin
				// stop the clock once the frames are done
				if (frame_end)
					state_d = wait_go ? ST_WAIT : more ? ST_SHIFT : cs_used_q ? ST_HOLD : ST_IDLE;
			end
			ST_WAIT: begin
				// clock held high for the selected bit times
				if (cnt_end)
					state_d = ST_SHIFT;
			end
			ST_HOLD: begin
				if (cnt_end)
					state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// counter restarts on each state change or period end
	assign cnt_d = (st_idle || cnt_end || state_d != state_q) ? '0 : cnt_q + CNT_W'(1);

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= ST_IDLE;
			cnt_q <= '0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sck_q <= SCK_MARK;
			sck_oe_q <= 1'b0;
		end else begin
			sck_oe_q <= master;
			if (fall)
				sck_q <= !SCK_MARK;
			else if (rise || !st_shift)
				sck_q <= SCK_MARK;
		end
	end

	// bit shifting; a wait of one to three bit times comes from wait_lim
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			bit_q <= '0;
			tx_sh_q <= '0;
		end else if (load) begin
			bit_q <= '0;
			tx_sh_q <= tx_hold_q;
		end else if (bit_step) begin
			bit_q <= bit_q + BIT_W'(1);
			tx_sh_q <= {tx_sh_q[MSB-1:0], 1'b0};
		end
	end

	// first bit out with the select; later bits on rises
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			dout_q <= DOUT_IDLE;
		else if (!serial_out_enable)
			dout_q <= DOUT_IDLE;
		else if (load)
			dout_q <= tx_hold_q[MSB];
		else if (bit_step)
			dout_q <= tx_sh_q[MSB-1];
	end

	// master samples the synchronised input on falls
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			rx_sh_q <= '0;
		else if (fall)
			rx_sh_q <= {rx_sh_q[MSB-1:0], sin_s};
	end

	// fifo count write arms a counted run; set wins over the start
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			fifo_go_q <= 1'b0;
			frames_q <= '0;
			count_mode_q <= 1'b0;
			cs_used_q <= 1'b0;
		end else begin
			fifo_go_q <= (fifo_frame_we && fifo_enable) || (fifo_go_q && !start_ok);
			if (start_ok) begin
				count_mode_q <= fifo_go_q || cs_mode;
				frames_q <= fifo_go_q ? fifo_frame_count : frame_count;
				cs_used_q <= cs_mode;
			end else if (frame_end) begin
				frames_q <= frames_q - FCNT_W'(1);
			end
		end
	end

	// select released after hold unless held active
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			cs_n_q <= {CS_NUM{CS_OFF}};
		else if (start_ok && cs_mode)
			cs_n_q <= ~cs_pick;
		else if ((st_hold && cnt_end) || st_idle)
			cs_n_q <= cs_hold_active ? cs_n_q : {CS_NUM{CS_OFF}};
	end

	////////////////////////////////////////////////////////////////////////
	// buffers and flags

	// write takes the data; slave output follows the hold register
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			tx_hold_q <= '0;
		else if (tx_wr)
			tx_hold_q <= tx_data_reg;
	end

	// hardware set wins over a write in the same cycle
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			tx_empty_q <= 1'b1;
		else if (m_take || s_take)
			tx_empty_q <= 1'b1;
		else if (tx_wr)
			tx_empty_q <= 1'b0;
	end

	// read clears, but a new frame in the same cycle wins
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rx_data_q <= '0;
			rx_full_q <= 1'b0;
		end else if (rx_new) begin
			rx_data_q <= master ? rx_sh_q : lrx_word_q;
			rx_full_q <= 1'b1;
		end else if (rx_data_re) begin
			rx_full_q <= 1'b0;
		end
	end

	// a dummy write arms only the next slave frame; repeated writes do not stack
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			armed_q <= 1'b0;
		else if (tx_wr && slave)
			armed_q <= 1'b1;
		else if (slv_rx_ev)
			armed_q <= 1'b0;
	end

	// requests follow the flags and their enables
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			tx_irq_q <= 1'b0;
			rx_irq_q <= 1'b0;
		end else begin
			tx_irq_q <= tx_empty_q && tx_int_enable;
			rx_irq_q <= rx_full_q && rx_int_enable;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link clock domain (slave)

	// sample on each falling edge of the external clock
	always_ff @(negedge sck_link or negedge rstn) begin
		if (!rstn) begin
			lcnt_q <= '0;
			lrx_sh_q <= '0;
			lrx_word_q <= '0;
			ltx_word_q <= '0;
			lrx_tgl_q <= 1'b0;
			lst_tgl_q <= 1'b0;
		end else if (slave_mode_select) begin
			lrx_sh_q <= {lrx_sh_q[MSB-1:0], serial_in_pin};
			if (lcnt_q == '0) begin
				ltx_word_q <= tx_hold_q;
				lst_tgl_q <= !lst_tgl_q;
			end
			if (lcnt_q == LAST_BIT) begin
				lcnt_q <= '0;
				lrx_word_q <= {lrx_sh_q[MSB-1:0], serial_in_pin};
				lrx_tgl_q <= !lrx_tgl_q;
			end else begin
				lcnt_q <= lcnt_q + BIT_W'(1);
			end
		end
	end

	// after reception ends the next rise presents the written data
	wire [FRAME_BITS-1:0] ltx_rot = ltx_word_q << lcnt_q;
	// lfirst_q marks the span from the first fall to the first rise
	always_ff @(posedge sck_link or negedge rstn) begin
		if (!rstn) begin
			slv_dout_q <= DOUT_IDLE;
			lfirst_q <= 1'b1;
		end else begin
			slv_dout_q <= (lcnt_q == '0) ? tx_hold_q[MSB] : ltx_rot[MSB];
			lfirst_q <= lcnt_q == '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// crossing into core_clk

	smot_sync #(
		.W(3)
	) u_sync (
		.clk(core_clk),
		.rstn(rstn),
		.d({serial_in_pin, lrx_tgl_q, lst_tgl_q}),
		.q(sync_q)
	);

	// toggle edge detect on the settled copies
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rx_tgl_old_q <= 1'b0;
			st_tgl_old_q <= 1'b0;
		end else begin
			rx_tgl_old_q <= sync_q[1];
			st_tgl_old_q <= sync_q[0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	// before the first edge the slave pin shows the written first bit
	// first bit must stand until the first rise, not only until the first fall
	wire slv_bit = (lcnt_q == '0) ? tx_hold_q[MSB] : lfirst_q ? ltx_word_q[MSB] : slv_dout_q;
	assign serial_out_pin = (slave && serial_out_enable) ? slv_bit : dout_q;
	assign sck_out = sck_q;
	assign sck_oe = sck_oe_q;
	assign chip_select_pin_n = cs_n_q;
	assign tx_buffer_empty_flag = tx_empty_q;
	assign rx_buffer_full_flag = rx_full_q;
	assign rx_data_reg = rx_data_q;
	assign tx_irq = tx_irq_q;
	assign rx_irq = rx_irq_q;

endmodule

// [verif/smot_props.sv]
/*
 * port-level checker for the spi mode-one engine.
 * assumes it is bound to smot_spi1 and sees only that module's ports.
 */
`timescale 1ns/10ps
module smot_props import smot_pkg::*; #(
	parameter int unsigned FRAME_BITS = FRAME_BITS_DEF,
	parameter int unsigned CS_NUM = CS_NUM_DEF
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic sck_link,
	input wire logic slave_mode_select,
	input wire logic serial_out_enable,
	input wire logic tx_enable,
	input wire logic tx_int_enable,
	input wire logic rx_int_enable,
	input wire logic cs_output_enable,
	input wire logic cs_hold_active,
	input wire logic [FRAME_BITS-1:0] tx_data_reg,
	input wire logic tx_data_we,
	input wire logic rx_data_re,
	input wire logic tx_buffer_empty_flag,
	input wire logic rx_buffer_full_flag,
	input wire logic tx_irq,
	input wire logic rx_irq,
	input wire logic sck_out,
	input wire logic sck_oe,
	input wire logic serial_out_pin,
	input wire logic [CS_NUM-1:0] chip_select_pin_n
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	////////////////////////////////////////////////////////////////
	// any select low counts as an active select
	wire cs_on = ~&chip_select_pin_n;
	logic [7:0] high_run_q;
	wire [7:0] high_run_d = !sck_out ? 8'h00 : (&high_run_q ? high_run_q : high_run_q + 8'h01);
	// cycles since sck last low; saturates so long idles never wrap
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			high_run_q <= 8'hFF;
		end else begin
			high_run_q <= high_run_d;
		end
	end

	// setup time first, then the first falling edge
	sequence clk_start;
		sck_out [*6] ##[1:8] !sck_out;
	endsequence

	// one high half period, then the fall
	sequence half_fall;
		sck_out [*4] ##1 !sck_out;
	endsequence

	////////////////////////////////////////////////////////////////
	idle_high_a: assert property (!sck_oe |-> sck_out)
		else $error("sck not parked high");
	dout_steady_a: assert property ($fell(sck_out) |-> $stable(serial_out_pin))
		else $error("data out moved on falling edge");
	empty_early_a: assert property (sck_oe && $rose(tx_buffer_empty_flag) |-> half_fall)
		else $error("empty flag not half period before fall");
	empty_clr_a: assert property (tx_data_we && tx_enable && tx_buffer_empty_flag |=> !tx_buffer_empty_flag)
		else $error("empty flag kept after write");
	tx_irq_a: assert property ($rose(tx_buffer_empty_flag) && tx_int_enable |=> tx_irq)
		else $error("no tx request");
	rx_irq_a: assert property ($rose(rx_buffer_full_flag) && rx_int_enable |=> rx_irq)
		else $error("no rx request");
	rd_clear_a: assert property (rx_data_re |=> !rx_buffer_full_flag)
		else $error("full flag kept after read");
	cs_setup_a: assert property ($rose(cs_on) |-> clk_start)
		else $error("clock start off setup time");
	cs_quiet_a: assert property (cs_output_enable && !cs_on |-> sck_out)
		else $error("sck ran without select");
	cs_hold_a: assert property ($fell(cs_on) |-> high_run_q >= 8'(CS_HOLD_CYC))
		else $error("select released before hold");
	hold_keep_a: assert property (cs_hold_active && cs_on |=> cs_on)
		else $error("held select released");
	slave_msb_a: assert property (slave_mode_select && serial_out_enable && tx_enable && tx_data_we && sck_link
		|=> serial_out_pin == $past(tx_data_reg[FRAME_BITS-1]))
		else $error("slave first bit missing");
endmodule

// [verif/smot_peer.sv]
/*
 * far-side spi peer: link master (15 ns clock, only inside a frame) when
 * the engine is a slave, link slave on select zero when it is a master.
 * assumes 8-bit frames, msb first.
 */
`timescale 1ns/10ps
module smot_peer (
	input wire logic go,
	input wire logic [7:0] tx_word,
	input wire logic sck_out,
	input wire logic cs_n,
	input wire logic serial_out_pin,
	output logic sck_link,
	output logic serial_in_pin,
	output logic [7:0] rx_word
);
	logic [7:0] sh;
	initial begin
		sck_link = 1'b1;
		serial_in_pin = 1'b0;
		rx_word = 8'h00;
		sh = 8'h00;
	end

	////////////////////////////////////////////////////////////////
	// frame starts from high mark, drive on rise, sample on fall
	always @(posedge go) begin
		sh = tx_word;
		serial_in_pin = sh[7];
		#3.2;
		repeat (8) begin
			#7.5 sck_link = 1'b0;
			rx_word = {rx_word[6:0], serial_out_pin};
			#7.5 sck_link = 1'b1;
			sh = {sh[6:0], sh[7]};
			serial_in_pin = sh[7];
		end
		// released line shows the inverse so a stale bit cannot pass
		serial_in_pin = ~serial_in_pin;
	end

	////////////////////////////////////////////////////////////////
	// slave answers only while selected
	always @(negedge cs_n) begin
		sh = tx_word;
		serial_in_pin = sh[7];
	end
	always @(negedge sck_out) begin
		if (!cs_n) rx_word = {rx_word[6:0], serial_out_pin};
	end
	// rotating word repeats each frame
	always @(posedge sck_out) begin
		if (!cs_n) begin
			sh = {sh[6:0], sh[7]};
			serial_in_pin = sh[7];
		end
	end
	always @(posedge cs_n) serial_in_pin = ~serial_in_pin;
endmodule

// [verif/tb.sv]
/*
 * testbench for smot_spi1: counted master runs with wait, fifo and held
 * select, then slave frames against the peer model.
 * assumes smot_peer and smot_props; link clock comes from the peer.
 */
`timescale 1ns/10ps
module tb import smot_pkg::*;;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic slave_mode_select = 1'b0, clock_output_enable = 1'b1, serial_out_enable = 1'b1;
	logic tx_enable = 1'b1, rx_enable = 1'b1, tx_int_enable = 1'b1, rx_int_enable = 1'b1;
	logic interframe_wait_sel_hi = 1'b0, interframe_wait_sel_lo = 1'b0;
	logic cs_output_enable = 1'b1, cs_hold_active = 1'b0, fifo_enable = 1'b0;
	logic fifo_frame_we = 1'b0, tx_data_we = 1'b0, rx_data_re = 1'b0, go = 1'b0;
	logic [3:0] cs_pin_enable = 4'h1;
	logic [1:0] cs_index = 2'h0;
	logic [7:0] frame_count = 8'h02, fifo_frame_count = 8'h00, tx_data_reg = 8'h00, peer_tx = 8'h00;
	logic [7:0] rx_data_reg, peer_rx;
	logic tx_buffer_empty_flag, rx_buffer_full_flag, tx_irq, rx_irq, sck_out, sck_oe, serial_out_pin;
	logic sck_link, serial_in_pin;
	logic [3:0] chip_select_pin_n;
	int n_errors = 0, checked = 0, cycles = 0;

	smot_peer u_smot_peer (.go(go), .tx_word(peer_tx), .sck_out(sck_out), .cs_n(chip_select_pin_n[0]),
		.serial_out_pin(serial_out_pin), .sck_link(sck_link), .serial_in_pin(serial_in_pin), .rx_word(peer_rx));
	smot_spi1 u_smot_spi1 (.*);

	////////////////////////////////////////////////////////////////
	always #5 core_clk = ~core_clk;
	// hang guard, far above the few thousand cycles the run needs
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			tally_and_finish();
		end
	end

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// inputs always move 1 ns after the rising edge
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic do_reset();
		rstn = 1'b0;
		cyc(2);
		rstn = 1'b1;
		cyc(2);
	endtask

	task automatic write_tx(input logic [7:0] d);
		tx_data_reg = d;
		tx_data_we = 1'b1;
		cyc(1);
		tx_data_we = 1'b0;
	endtask

	task automatic read_rx(input logic [7:0] d);
		chk("full_set", rx_buffer_full_flag, 1);
		chk("rx_data", rx_data_reg, d);
		rx_data_re = 1'b1;
		cyc(1);
		rx_data_re = 1'b0;
		chk("full_clr", rx_buffer_full_flag, 0);
	endtask

	////////////////////////////////////////////////////////////////
	// counted master run; gap is the high run before frame two
	task automatic master_run(input logic [1:0] w, input logic hold, input logic fifo, input logic [7:0] n,
		input logic [7:0] d);
		int falls, run, gap;
		logic prev;
		falls = 0;
		run = 0;
		gap = 0;
		prev = 1'b1;
		{interframe_wait_sel_hi, interframe_wait_sel_lo} = w;
		cs_hold_active = hold;
		cs_output_enable = !fifo;
		fifo_enable = fifo;
		frame_count = n;
		peer_tx = ~d;
		if (fifo) begin
			fifo_frame_count = n;
			fifo_frame_we = 1'b1;
			cyc(1);
			fifo_frame_we = 1'b0;
		end else begin
			write_tx(d);
		end
		repeat (500) begin
			if (prev && !sck_out) begin
				falls++;
				if (falls == 9) gap = run;
			end
			run = sck_out ? run + 1 : 0;
			prev = sck_out;
			cyc(1);
		end
		chk("sck_falls", falls, 8 * n);
		if (n > 1) chk("wait_gap", gap, SCK_HALF_DEF * (1 + 2 * w));
		chk("select", chip_select_pin_n, hold ? 4'hE : 4'hF);
		chk("sck_oe", sck_oe, 1);
		chk("empty_end", tx_buffer_empty_flag, 1);
		if (!fifo) chk("peer_rx", peer_rx, d);
		if (!fifo) read_rx(~d);
	endtask

	// peer clocks one frame from the mark level, then the link rests high
	task automatic peer_frame(input logic [7:0] p);
		peer_tx = p;
		go = 1'b1;
		cyc(1);
		go = 1'b0;
		cyc(30);
	endtask

	// slave frame: write at mark level, peer clocks eight bits
	task automatic slave_frame(input logic [7:0] d, input logic [7:0] p);
		write_tx(d);
		chk("empty_clr", tx_buffer_empty_flag, 0);
		chk("first_bit", serial_out_pin, d[7]);
		chk("sck_oe_slv", sck_oe, 0);
		peer_frame(p);
		chk("empty_set", tx_buffer_empty_flag, 1);
		chk("tx_irq", tx_irq, 1);
		chk("rx_irq", rx_irq, 1);
		chk("slave_out", peer_rx, d);
		read_rx(p);
	endtask

	// dummy-write reception, then switch to transmit
	task automatic rx_then_tx(input logic [7:0] p, input logic [7:0] d);
		serial_out_enable = 1'b0;
		write_tx(8'hFF);
		peer_frame(p);
		chk("rx_pin_idle", serial_out_pin, DOUT_IDLE);
		chk("rx_irq_rx", rx_irq, 1);
		read_rx(p);
		write_tx(8'hFF);
		peer_frame(~p);
		read_rx(~p);
		peer_frame(p);
		chk("unarmed", rx_buffer_full_flag, 0);
		serial_out_enable = 1'b1;
		rx_int_enable = 1'b0;
		rx_enable = 1'b0;
		write_tx(d);
		peer_frame(8'h00);
		chk("switch_out", peer_rx, d);
		chk("switch_empty", tx_buffer_empty_flag, 1);
		chk("switch_full", rx_buffer_full_flag, 0);
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		do_reset();
		for (int w = 0; w < 4; w++) begin
			master_run(2'(w), 1'b0, 1'b0, 8'h02, 8'hA5 ^ 8'(w));
		end
		master_run(2'h0, 1'b0, 1'b1, 8'h03, 8'hA6);
		master_run(2'h0, 1'b1, 1'b0, 8'h01, 8'h3C);
		slave_mode_select = 1'b1;
		clock_output_enable = 1'b0;
		cs_hold_active = 1'b0;
		fifo_enable = 1'b0;
		do_reset();
		slave_frame(8'hC3, 8'h5A);
		slave_frame(8'h42, 8'h7E);
		rx_then_tx(8'h96, 8'h5C);
		tally_and_finish();
	end
endmodule

bind smot_spi1 smot_props #(.FRAME_BITS(FRAME_BITS), .CS_NUM(CS_NUM)) u_smot_props (.*);
